/* File: src/api_frame_codec_params.svh */
`ifndef API_FRAME_CODEC_PARAMS_SVH
`define API_FRAME_CODEC_PARAMS_SVH

// framing bytes
`define DELIM_BYTE 8'h7e
`define ESC_BYTE 8'h7d
`define ESC_XOR 8'h20
`define XON_BYTE 8'h11
`define XOFF_BYTE 8'h13
`define CKS_GOOD 8'hff

// error status frame sent back to the host
`define STATUS_TYPE 8'hc0
`define STATUS_LEN 16'h0002
`define ERR_CHECKSUM 8'h01
`define ERR_EMPTY 8'h02

// transmit buffer shape
`define TX_FIFO_DEPTH 8
`define TX_WORD_W 24

`define LEN_ZERO 16'h0000
`define LEN_ONE 16'h0001

`endif

/* File: src/api_frame_codec_pkg.sv */
package api_frame_codec_pkg;

  // host link operation, values 0, 1 and 2 in declaration order
  typedef enum logic [1:0] {
    MODE_TRANSPARENT,
    MODE_FRAMED,
    MODE_ESCAPED
  } mode_t;

  // one frame-data byte queued for sending, with the frame's data length
  typedef struct packed {
    logic [15:0] len;
    logic [7:0] data;
  } tx_word_t;

  // one decoded frame-data byte handed to the frame logic
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } rx_byte_t;

  // running 8-bit checksum sum
  function automatic logic [7:0] cks_add(input logic [7:0] acc, input logic [7:0] b);
    cks_add = acc + b;
  endfunction

endpackage

/* File: src/byte_fifo.sv */
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign empty = wr_ptr == rd_ptr;
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule

/* File: src/byte_escaper.sv */
`timescale 1ns/1ns
`include "api_frame_codec_params.svh"
module byte_escaper (
  input wire logic clk,
  input wire logic rst,
  input wire logic esc_on,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_raw,
  output logic in_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  logic pend;
  logic [7:0] pend_byte;
  logic slot;
  logic in_fire;
  logic stuff;

  // exactly the four reserved values need stuffing
  function automatic logic reserved(input logic [7:0] b);
    reserved = (b == `DELIM_BYTE) || (b == `ESC_BYTE) ||
               (b == `XON_BYTE) || (b == `XOFF_BYTE); // [RL15]
  endfunction

  // output register is free when empty or being drained this cycle
  assign slot = !tx_valid || tx_ready;
  assign in_ready = slot && !pend;
  assign in_fire = in_valid && in_ready;
  // the leading delimiter arrives raw and is never stuffed
  assign stuff = esc_on && !in_raw && reserved(in_data); // [RL14] [RL19]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      pend <= 1'b0;
      pend_byte <= 8'h00;
    end else if (slot) begin
      tx_valid <= pend || in_fire;
      if (pend) begin
        tx_data <= pend_byte;
        pend <= 1'b0;
      end else if (in_fire) begin
        tx_data <= stuff ? `ESC_BYTE : in_data; // [RL16]
        pend <= stuff;
        pend_byte <= in_data ^ `ESC_XOR; // [RL14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_esc_pair;
    @(posedge clk) disable iff (rst)
    (in_fire && stuff) |=> (tx_valid && tx_data == `ESC_BYTE && pend &&
                            pend_byte == ($past(in_data) ^ `ESC_XOR));
  endproperty
  a_esc_pair: assert property (p_esc_pair) else $error("escape pair malformed"); // [RL14]

  property p_plain_pass;
    @(posedge clk) disable iff (rst)
    (in_fire && !stuff) |=> (tx_valid && tx_data == $past(in_data) && !pend);
  endproperty
  a_plain_pass: assert property (p_plain_pass) else $error("byte altered"); // [RL15]

  c_escape: cover property (@(posedge clk) disable iff (rst) in_fire && stuff);
endmodule

/* File: src/api_frame_codec.sv */
// Operation
// (RL1) mode 0 passes bytes through unframed (default), 1 frames, 2 frames with escaping
// (RL2) escaped framing only on the UART; on SPI mode 2 behaves as mode 1
// (RL3) framing works on both the UART and the SPI host link
// (RL4) every frame starts with delimiter 0x7E, which marks a new frame
// (RL5) two length bytes follow, MSB first, counting only frame-data bytes
// (RL6) first frame-data byte is the frame type
// (RL7) multi-byte values travel most significant byte first
// (RL8) sender appends 0xFF minus low 8 bits of the frame-data sum
// (RL9) receiver sums data plus checksum; valid only when low byte is 0xFF
// (RL10) bytes before a recognised delimiter are dropped silently
// (RL11) a bad or failed frame makes the device send a status frame
// (RL12) a frame with a bad checksum is invalid and not acted upon
// (RL13) escaped mode: unescaped 0x7E restarts the frame, discarding partial data
// (RL14) escaping sends 0x7D then byte XOR 0x20; receiver undoes it
// (RL15) only 0x7E, 0x7D, 0x11 and 0x13 are escaped
// (RL16) escaping applies in both directions in escaped mode
// (RL17) length and checksum use unescaped byte values
// (RL18) host should skip frame types it does not know
// (RL19) the leading delimiter is never escaped
`timescale 1ns/1ns
`include "api_frame_codec_params.svh"
module api_frame_codec
  import api_frame_codec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire mode_t host_framing_mode_select,
  input wire logic link_is_spi,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  output logic link_tx_valid,
  output logic [7:0] link_tx_data,
  input wire logic link_tx_ready,
  input wire logic usr_tx_valid,
  input wire tx_word_t usr_tx_word,
  output logic usr_tx_ready,
  output logic usr_rx_valid,
  output rx_byte_t usr_rx,
  output logic frame_good,
  output logic frame_bad,
  output logic frame_abort
);
  typedef enum logic [2:0] {R_HUNT, R_LEN_HI, R_LEN_LO, R_DATA, R_CKS} rx_state_t;
  typedef enum logic [2:0] {
    T_IDLE, T_DELIM, T_LEN_HI, T_LEN_LO, T_DATA, T_STAT_TYPE, T_STAT_CODE, T_CKS
  } tx_state_t;
  mode_t eff_mode;
  logic transp;
  logic esc_on;

  // SPI cannot carry escaped framing, so mode 2 falls back to mode 1 there
  assign eff_mode = (link_is_spi && host_framing_mode_select == MODE_ESCAPED) ?
                    MODE_FRAMED : host_framing_mode_select; // [RL2] [RL3]
  assign transp = eff_mode == MODE_TRANSPARENT; // [RL1]
  assign esc_on = eff_mode == MODE_ESCAPED;

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  rx_state_t rstate;
  rx_state_t next_rstate;
  logic esc_seen;
  logic next_esc_seen;
  logic [15:0] rlen;
  logic [15:0] next_rlen;
  logic [15:0] remain;
  logic [15:0] next_remain;
  logic [7:0] rsum;
  logic [7:0] next_rsum;
  logic [7:0] rx_byte;
  logic rx_is_esc;
  logic rx_take;
  logic rx_raw_delim;
  logic rx_restart;
  logic rx_data_fire;
  logic rx_cks_fire;
  logic [7:0] rx_total;
  logic rx_ok;
  // escape marker is swallowed and the next byte unflipped before any counting
  assign rx_is_esc = link_rx_valid && esc_on && !esc_seen && link_rx_data == `ESC_BYTE;
  assign rx_byte = esc_seen ? (link_rx_data ^ `ESC_XOR) : link_rx_data; // [RL14] [RL16]
  assign rx_take = link_rx_valid && !rx_is_esc;
  assign rx_raw_delim = link_rx_valid && !esc_seen && link_rx_data == `DELIM_BYTE; // [RL4]
  // in escaped mode a raw delimiter can only be a frame start
  assign rx_restart = esc_on && rx_raw_delim; // [RL13]
  assign next_esc_seen = rx_is_esc || (esc_seen && !link_rx_valid);
  assign rx_data_fire = rstate == R_DATA && rx_take && !rx_restart;
  assign rx_cks_fire = rstate == R_CKS && rx_take && !rx_restart;
  assign rx_total = cks_add(rsum, rx_byte); // [RL9] [RL17]
  // empty frames carry no type byte, so they count as received wrongly
  assign rx_ok = rx_total == `CKS_GOOD && rlen != `LEN_ZERO; // [RL9]
  // length arrives big-endian and excludes delimiter, length and checksum
  assign next_rlen = (rstate == R_LEN_HI && rx_take) ? {rx_byte, 8'h00} :
                     (rstate == R_LEN_LO && rx_take) ? {rlen[15:8], rx_byte} :
                     rlen; // [RL5] [RL7]
  assign next_remain = (rstate == R_LEN_LO && rx_take) ? {rlen[15:8], rx_byte} :
                       rx_data_fire ? remain - `LEN_ONE : remain;
  assign next_rsum = (rstate == R_LEN_HI) ? 8'h00 :
                     rx_data_fire ? rx_total : rsum; // [RL17]
  // frame walker; anything outside a frame is dropped without a trace
  always_comb begin
    next_rstate = rstate;
    unique case (rstate)
      R_HUNT: if (rx_raw_delim) next_rstate = R_LEN_HI; // [RL10]
      R_LEN_HI: if (rx_take) next_rstate = R_LEN_LO;
      R_LEN_LO: if (rx_take) next_rstate = ({rlen[15:8], rx_byte} == `LEN_ZERO) ?
                                            R_CKS : R_DATA;
      R_DATA: if (rx_take && remain == `LEN_ONE) next_rstate = R_CKS;
      R_CKS: if (rx_take) next_rstate = R_HUNT;
    endcase
    if (rx_restart) next_rstate = R_LEN_HI; // [RL13]
    if (transp) next_rstate = R_HUNT;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rstate <= R_HUNT;
      esc_seen <= 1'b0;
      rlen <= `LEN_ZERO;
      remain <= `LEN_ZERO;
      rsum <= 8'h00;
    end else begin
      rstate <= next_rstate;
      esc_seen <= next_esc_seen;
      rlen <= next_rlen;
      remain <= next_remain;
      rsum <= next_rsum;
    end
  end
  // decoded bytes to the frame logic; good or bad verdict comes with the checksum
  always_ff @(posedge clk) begin
    if (rst) begin
      usr_rx_valid <= 1'b0;
      usr_rx <= '0;
      frame_good <= 1'b0;
      frame_bad <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      usr_rx_valid <= transp ? link_rx_valid : rx_data_fire; // [RL1] [RL10]
      usr_rx.data <= transp ? link_rx_data : rx_byte;
      usr_rx.first <= !transp && remain == rlen; // [RL6]
      frame_good <= !transp && rx_cks_fire && rx_ok; // [RL9]
      frame_bad <= !transp && rx_cks_fire && !rx_ok; // [RL12]
      frame_abort <= rx_restart && rstate != R_HUNT; // [RL13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status request from the receiver to the sender
  logic status_pend;
  logic [7:0] stat_code;
  logic stat_start;
  // a new failure in the same cycle as the pickup is kept, not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      status_pend <= 1'b0;
      stat_code <= 8'h00;
    end else begin
      if (stat_start) status_pend <= 1'b0;
      if (frame_bad) begin
        status_pend <= 1'b1; // [RL11]
        stat_code <= (rlen == `LEN_ZERO) ? `ERR_EMPTY : `ERR_CHECKSUM;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit side: buffer, framer, escaper
  tx_state_t tstate;
  tx_state_t next_tstate;
  logic f_valid;
  logic f_ready;
  logic [`TX_WORD_W-1:0] f_bits;
  tx_word_t f_word;
  logic src_stat;
  logic [15:0] tlen;
  logic [15:0] tcnt;
  logic [7:0] tsum;
  logic e_valid;
  logic e_ready;
  logic e_raw;
  logic [7:0] e_data;
  logic e_fire;
  byte_fifo #(.WIDTH(`TX_WORD_W), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(usr_tx_valid),
    .in_data(usr_tx_word),
    .in_ready(usr_tx_ready),
    .out_valid(f_valid),
    .out_data(f_bits),
    .out_ready(f_ready)
  );
  assign f_word = tx_word_t'(f_bits);
  assign e_fire = e_valid && e_ready;
  assign stat_start = tstate == T_IDLE && !transp && status_pend;
  // byte source per state; the checksum closes every frame
  always_comb begin
    e_valid = 1'b1;
    e_raw = 1'b0;
    e_data = 8'h00;
    f_ready = 1'b0;
    next_tstate = tstate;
    unique case (tstate)
      T_IDLE: begin
        e_valid = transp && f_valid; // [RL1]
        e_raw = 1'b1;
        e_data = f_word.data;
        f_ready = transp && e_ready;
        if (!transp && (status_pend || f_valid)) next_tstate = T_DELIM;
      end
      T_DELIM: begin
        e_raw = 1'b1; // [RL19]
        e_data = `DELIM_BYTE; // [RL4]
        if (e_ready) next_tstate = T_LEN_HI;
      end
      T_LEN_HI: begin
        e_data = tlen[15:8]; // [RL5] [RL7]
        if (e_ready) next_tstate = T_LEN_LO;
      end
      T_LEN_LO: begin
        e_data = tlen[7:0];
        if (e_ready) next_tstate = src_stat ? T_STAT_TYPE : T_DATA;
      end
      T_DATA: begin
        e_valid = f_valid;
        e_data = f_word.data;
        f_ready = e_ready;
        if (e_fire && tcnt == `LEN_ONE) next_tstate = T_CKS;
      end
      T_STAT_TYPE: begin
        e_data = `STATUS_TYPE; // [RL11]
        if (e_ready) next_tstate = T_STAT_CODE;
      end
      T_STAT_CODE: begin
        e_data = stat_code;
        if (e_ready) next_tstate = T_CKS;
      end
      T_CKS: begin
        e_data = `CKS_GOOD - tsum; // [RL8] [RL17]
        if (e_ready) next_tstate = T_IDLE;
      end
    endcase
  end
  // a zero length from the user is sent as one so the queued byte still drains
  always_ff @(posedge clk) begin
    if (rst) begin
      tstate <= T_IDLE;
      src_stat <= 1'b0;
      tlen <= `LEN_ZERO;
      tcnt <= `LEN_ZERO;
      tsum <= 8'h00;
    end else begin
      tstate <= next_tstate;
      if (tstate == T_IDLE) begin
        src_stat <= status_pend;
        tlen <= status_pend ? `STATUS_LEN :
                (f_word.len == `LEN_ZERO) ? `LEN_ONE : f_word.len;
        tcnt <= (f_word.len == `LEN_ZERO) ? `LEN_ONE : f_word.len;
        tsum <= 8'h00;
      end
      if (e_fire && (tstate == T_DATA || tstate == T_STAT_TYPE || tstate == T_STAT_CODE))
        tsum <= cks_add(tsum, e_data); // [RL8]
      if (e_fire && tstate == T_DATA) tcnt <= tcnt - `LEN_ONE;
    end
  end

  byte_escaper u_escaper (
    .clk(clk),
    .rst(rst),
    .esc_on(esc_on),
    .in_valid(e_valid),
    .in_data(e_data),
    .in_raw(e_raw),
    .in_ready(e_ready),
    .tx_valid(link_tx_valid),
    .tx_data(link_tx_data),
    .tx_ready(link_tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_spi_plain;
    link_is_spi |-> !esc_on;
  endproperty
  a_spi_plain: assert property (p_spi_plain) else $error("escaping on spi"); // [RL2]
  property p_transparent;
    (transp && link_rx_valid) |=> (usr_rx_valid && usr_rx.data == $past(link_rx_data));
  endproperty
  a_transparent: assert property (p_transparent) else $error("pass-through lost"); // [RL1]
  property p_hunt_silent;
    (rstate == R_HUNT && !transp) |=> !usr_rx_valid && !frame_good && !frame_bad;
  endproperty
  a_hunt_silent: assert property (p_hunt_silent) else $error("stray byte reported"); // [RL10]
  property p_delim_start;
    (rstate == R_HUNT && rx_raw_delim && !transp) |=> rstate == R_LEN_HI;
  endproperty
  a_delim_start: assert property (p_delim_start) else $error("delimiter missed"); // [RL4]
  // the old partial sum is only dropped once the walker sits in the length state
  property p_restart;
    (rx_restart && !transp) |=> rstate == R_LEN_HI ##1 rsum == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on delimiter"); // [RL13]
  property p_check_good;
    (!transp && rx_cks_fire && rx_total == `CKS_GOOD && rlen != `LEN_ZERO)
      |=> frame_good && !frame_bad;
  endproperty
  a_check_good: assert property (p_check_good) else $error("good frame refused"); // [RL9]
  property p_bad_status;
    frame_bad |=> status_pend ##[0:3] tstate != T_IDLE;
  endproperty
  a_bad_status: assert property (p_bad_status) else $error("no status after bad frame"); // [RL11]
  property p_bad_not_good;
    frame_bad |-> !frame_good && !$past(rx_ok);
  endproperty
  a_bad_not_good: assert property (p_bad_not_good) else $error("bad frame accepted"); // [RL12]
  property p_len_order;
    (tstate == T_LEN_HI && e_fire) |-> e_data == tlen[15:8] ##1 tstate == T_LEN_LO;
  endproperty
  a_len_order: assert property (p_len_order) else $error("length order wrong"); // [RL5]
  property p_cks_out;
    (tstate == T_CKS && e_fire) |-> cks_add(e_data, tsum) == `CKS_GOOD;
  endproperty
  a_cks_out: assert property (p_cks_out) else $error("checksum wrong"); // [RL8]
  property p_delim_raw;
    tstate == T_DELIM |-> e_raw && e_data == `DELIM_BYTE;
  endproperty
  a_delim_raw: assert property (p_delim_raw) else $error("delimiter escaped"); // [RL19]
  c_good: cover property (frame_good);
  c_bad: cover property (frame_bad);
  c_abort: cover property (frame_abort);
  c_status: cover property (tstate == T_STAT_TYPE && e_fire);
endmodule

/* File: tb/host_link_model.sv */
`timescale 1ns/1ns
// host end of the serial link: sends queued bytes, collects device bytes
module host_link_model (
  input wire logic clk,
  input wire logic rst,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] sendq[$];
  logic [7:0] gotq[$];
  int hold = 0;
  bit slow = 0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  ////////////////////////////////////////
  // one byte per cycle; an idle line toggles so stale data never matches
  always @(posedge clk) begin
    if (!rst && sendq.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data <= sendq.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end

  ////////////////////////////////////////
  // stall for hold cycles, then take every cycle, or every other when slow
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      gotq.push_back(tx_data); // bytes kept raw, unknown types left alone
    end
    if (hold > 0) begin
      hold <= hold - 1;
    end
    tx_ready <= !rst && hold <= 1 && !(slow && tx_ready);
  end
endmodule

/* File: tb/api_frame_codec_tb.sv */
`timescale 1ns/1ns
module api_frame_codec_tb;
  import api_frame_codec_pkg::*;
  typedef logic [7:0] bq_t[$];
  typedef struct {mode_t m; logic spi; logic [7:0] t; logic [7:0] d; bit bad;} row_t;
  logic clk = 0;
  logic rst = 1;
  logic spi = 0;
  logic tv = 0;
  logic rdy_s;
  logic full_seen;
  mode_t mode = MODE_TRANSPARENT;
  tx_word_t tw = '0;
  logic rv, ltv, ltr, ur, uv, fg, fb, fa;
  logic [7:0] rd, ltd;
  rx_byte_t urx;
  rx_byte_t rxq[$];
  bq_t e;
  bit esc;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int ng, nb, na;
  row_t rows[8];

  api_frame_codec dut (.clk(clk), .rst(rst), .host_framing_mode_select(mode),
    .link_is_spi(spi), .link_rx_valid(rv), .link_rx_data(rd), .link_tx_valid(ltv),
    .link_tx_data(ltd), .link_tx_ready(ltr), .usr_tx_valid(tv), .usr_tx_word(tw),
    .usr_tx_ready(ur), .usr_rx_valid(uv), .usr_rx(urx), .frame_good(fg),
    .frame_bad(fb), .frame_abort(fa));
  host_link_model host (.clk(clk), .rst(rst), .rx_valid(rv), .rx_data(rd),
    .tx_valid(ltv), .tx_data(ltd), .tx_ready(ltr));

  always #50 clk = ~clk;

  ////////////////////////////////////////
  // gather decoded bytes and verdict pulses; a hang counts as a failure
  always @(posedge clk) begin
    if (uv === 1'b1) rxq.push_back(urx);
    if (fg === 1'b1) ng++;
    if (fb === 1'b1) nb++;
    if (fa === 1'b1) na++;
    cyc++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end

  // ready is combinational, so take it once it has settled
  always @(negedge clk) begin
    rdy_s = ur;
    if (ur === 1'b0) full_seen = 1'b1;
  end

  ////////////////////////////////////////
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // wire image of a frame; the leading delimiter is never escaped
  function automatic bq_t mk(bq_t d, bit x, bit badc);
    bq_t o, b;
    logic [7:0] s;
    s = 8'h00;
    o = {8'h7e};
    b = {8'(d.size() >> 8), 8'(d.size())};
    foreach (d[i]) begin
      b.push_back(d[i]);
      s += d[i];
    end
    b.push_back(8'hff - s + 8'(badc));
    foreach (b[i])
      if (x && b[i] inside {8'h7e, 8'h7d, 8'h11, 8'h13}) o = {o, 8'h7d, b[i] ^ 8'h20};
      else o.push_back(b[i]);
    return o;
  endfunction

  task automatic clear();
    rxq.delete();
    host.gotq.delete();
    ng = 0;
    nb = 0;
    na = 0;
  endtask

  // waits for the host to finish sending and for n bytes back
  task automatic settle(int n);
    for (int i = 0; i < 600 && (host.gotq.size() < n || host.sendq.size() > 0); i++)
      @(posedge clk);
    repeat (10) @(posedge clk);
  endtask

  task automatic cmp_tx(string n, bq_t x);
    check({n, "_len"}, host.gotq.size(), x.size());
    foreach (x[i]) if (i < host.gotq.size()) check(n, host.gotq[i], x[i]);
  endtask

  // request held from one edge until the edge where ready is high
  task automatic push(logic [15:0] len, logic [7:0] d);
    tv <= 1'b1;
    tw <= {len, d};
    do @(posedge clk); while (rdy_s !== 1'b1);
  endtask

  task automatic tx_frame(bq_t d, bit x);
    clear();
    foreach (d[i]) push(16'(d.size()), d[i]);
    tv <= 1'b0;
    settle(mk(d, x, 0).size());
    cmp_tx("link_tx", mk(d, x, 0));
  endtask

  task automatic set_mode(mode_t m, logic s);
    mode <= m;
    spi <= s;
    repeat (3) @(posedge clk);
    clear();
  endtask

  ////////////////////////////////////////
  initial begin
    rows = '{'{MODE_FRAMED, 0, 8'h08, 8'h17, 0}, '{MODE_FRAMED, 0, 8'h08, 8'h7e, 0},
      '{MODE_FRAMED, 1, 8'h10, 8'h11, 1}, '{MODE_ESCAPED, 0, 8'h08, 8'h7e, 0},
      '{MODE_ESCAPED, 0, 8'h7d, 8'h11, 0}, '{MODE_ESCAPED, 0, 8'h17, 8'h13, 1},
      '{MODE_ESCAPED, 1, 8'h08, 8'h7d, 0}, '{MODE_FRAMED, 0, 8'h8a, 8'h00, 0}};
    repeat (20) @(posedge clk);
    check("rst_ready", ur, 1);
    check("rst_outs", {ltv, uv, fg, fb, fa}, 0);
    rst <= 1'b0;
    set_mode(MODE_TRANSPARENT, 0);
    host.sendq = {8'h7e, 8'h11, 8'h7d};
    settle(0);
    check("raw_count", rxq.size(), 3);
    check("raw_byte", rxq[0].data, 8'h7e);
    check("raw_verdicts", ng + nb, 0);
    push(16'h0001, 8'h7e);
    tv <= 1'b0;
    settle(1);
    cmp_tx("raw_tx", {8'h7e});
    // ordinary frames: junk first, then one two-byte frame per row
    foreach (rows[k]) begin
      set_mode(rows[k].m, rows[k].spi);
      esc = rows[k].m == MODE_ESCAPED && !rows[k].spi;
      host.sendq = {8'h55, 8'h31, mk({rows[k].t, rows[k].d}, esc, rows[k].bad)};
      e = {};
      if (rows[k].bad) e = mk({8'hc0, 8'h01}, esc, 0);
      settle(e.size());
      check("rx_count", rxq.size(), 2);
      check("type_byte", rxq[0], {1'b1, rows[k].t});
      check("data_byte", rxq[1], {1'b0, rows[k].d});
      check("good", ng, !rows[k].bad);
      check("bad", nb, rows[k].bad);
      cmp_tx("status", e);
    end
    // raw delimiter in mid-frame restarts reception without a status frame
    set_mode(MODE_ESCAPED, 0);
    host.sendq = {8'h7e, 8'h00, 8'h03, 8'h08, 8'h55, mk({8'h08, 8'h17}, 1, 0)};
    settle(0);
    check("abort", na, 1);
    check("abort_good", ng, 1);
    check("abort_tx", host.gotq.size(), 0);
    set_mode(MODE_FRAMED, 0);
    host.sendq = {8'h7e, 8'h00, 8'h00, 8'hff};
    settle(6);
    check("zero_len", nb, 1);
    cmp_tx("zero_status", mk({8'hc0, 8'h02}, 0, 0));
    // reset in mid-frame must forget the partial frame and the queued word
    set_mode(MODE_FRAMED, 0);
    host.sendq = {8'h7e, 8'h00, 8'h05, 8'h08};
    push(16'h0003, 8'h08);
    rst <= 1'b1;
    tv <= 1'b0;
    repeat (2) @(posedge clk);
    check("mid_rst_outs", {ltv, uv, fg, fb, fa}, 0);
    check("mid_rst_ready", ur, 1);
    rst <= 1'b0;
    clear();
    host.sendq = mk({8'h08, 8'h17}, 0, 0);
    settle(0);
    check("mid_rst_good", ng, 1);
    check("mid_rst_tx", host.gotq.size(), 0);
    set_mode(MODE_ESCAPED, 0);
    tx_frame({8'h08, 8'h7e, 8'h11, 8'h13, 8'h7d, 8'h20}, 1);
    set_mode(MODE_ESCAPED, 1);
    tx_frame({8'h08, 8'h7e, 8'h11}, 0);
    // fill the buffer against a stalled, then slow, host
    set_mode(MODE_FRAMED, 0);
    e = {};
    for (int i = 0; i < 12; i++) e.push_back(8'(i * 21));
    host.hold = 60;
    host.slow = 1;
    full_seen = 1'b0;
    tx_frame(e, 0);
    check("fifo_full", full_seen, 1);
    wrap_up();
  end
endmodule
